/* File: bench/iak_cpu_model.sv */
// bus master model running one cycle per go: 0 ack, 1 write, 2 read, 3 io read
// assumes go, kind and adr held from the edge before the cycle starts
`timescale 1ns/100ps
module iak_cpu_model (
    input  wire logic        clk_sys,
    input  wire logic        go,
    input  wire logic [1:0]  kind,
    input  wire logic [7:0]  adr,
    input  wire logic        hold,
    output iak_pkg::iak_bus_s bus
);
    logic [2:0] ph = 3'h0;
    initial bus = 16'h5000;
    always @(posedge clk_sys)
    begin
        bus.phlda <= hold;
        bus.psync <= (ph == 3'h0 && go) || ph == 3'h1;
        bus.pstval_n <= !(ph == 3'h0 && go);
        bus.pdbin <= (ph == 3'h2 || ph == 3'h3) && kind != 2'h1;
        ph <= (ph == 3'h0) ? {2'h0, go} : ((ph == 3'h4) ? 3'h0 : ph + 3'h1);
        if (ph == 3'h0 && go)
        begin
            bus.sinta <= (kind == 2'h0);
            bus.swo_n <= (kind != 2'h1);
            bus.sinp <= (kind == 2'h3);
            bus.sout <= 1'b0;
            bus.addr <= adr;
        end
        else if (ph == 3'h0)
            bus.addr <= ~bus.addr;
    end
endmodule

/* File: bench/iak_sequencer_props.sv */
// port checker for the acknowledge sequencer
// assumes one clock domain, bound onto every iak_sequencer
`timescale 1ns/100ps
module iak_sequencer_chk (
    input wire logic         clk_sys,
    input wire logic         nrst,
    input wire logic         clk_en,
    input iak_pkg::iak_bus_s bus,
    input wire logic         ack_in_progress_n,
    input wire logic         phantom_drive,
    input wire logic         phantom_oe_n,
    input wire logic         local_ack_strobe_n,
    input wire logic         mem_select_n,
    input wire logic         board_select,
    input wire logic         rdy
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    hold_suspends_a: assert property (bus.phlda |-> ack_in_progress_n)
        else $error("ack shown during hold");
    phantom_drive_a: assert property (phantom_drive == !ack_in_progress_n && phantom_oe_n == ack_in_progress_n)
        else $error("phantom not tied to ack");
    mem_block_a: assert property (!ack_in_progress_n |-> mem_select_n)
        else $error("memory on during ack");
    board_sel_a: assert property (!ack_in_progress_n |-> board_select)
        else $error("no board select during ack");
    ack_waits_a: assert property ($rose(bus.psync) && !ack_in_progress_n |-> !rdy ##1 !rdy)
        else $error("forced waits missing");
    first_waits_a: assert property ($rose(bus.psync) && bus.sinta && !bus.phlda |-> !rdy ##1 !rdy)
        else $error("first ack waits missing");
    strobe_gate_a: assert property (local_ack_strobe_n == !(!ack_in_progress_n && bus.pdbin))
        else $error("strobe gating wrong");
    ack_set_a: assert property ((clk_en && bus.psync && !bus.pstval_n) ##1
        (clk_en && bus.psync && bus.sinta) |=> (bus.phlda || !ack_in_progress_n))
        else $error("ack not set");
    hold_keep_a: assert property (!ack_in_progress_n ##1 bus.phlda[*3] ##1 !bus.phlda |-> !ack_in_progress_n)
        else $error("ack lost across hold");
    ack_reset_a: assert property ($rose(nrst) |-> ack_in_progress_n)
        else $error("ack after reset");
    cover property (!local_ack_strobe_n);
    cover property (!ack_in_progress_n ##1 bus.phlda);
    cover property ($rose(ack_in_progress_n));
endmodule
bind iak_sequencer iak_sequencer_chk i_chk (.clk_sys, .nrst, .clk_en, .bus, .ack_in_progress_n,
    .phantom_drive, .phantom_oe_n, .local_ack_strobe_n, .mem_select_n, .board_select, .rdy);

/* File: bench/test_iak_sequencer.sv */
// self-checking bench for the acknowledge sequencer
// assumes the cpu model and the checker are compiled first
`timescale 1ns/100ps
module test_iak_sequencer;
    typedef struct packed {logic [7:0] a; logic [6:0] irq; logic [8:0] exp;} iak_row_s;
    logic              clk_sys = 1'b0;
    logic              nrst = 1'b0;
    logic              go = 1'b0;
    logic              hold = 1'b0;
    logic              jmp = 1'b0;
    logic              hit = 1'b0;
    logic [1:0]        kind = 2'h0;
    logic [7:0]        adr = 8'h00;
    logic [3:0]        wsw = 4'h1;
    iak_pkg::iak_irq_s irq = '0;
    iak_pkg::iak_bus_s bus;
    logic              ack_n, stb_n, msel_n, ssel_n, memsel_n;
    logic [7:0]        irql, snap;
    int                miscompares = 0;
    int                total_checks = 0;
    iak_row_s rows [6] = '{'{8'ha0, 7'h00, 9'h08c}, '{8'ha1, 7'h7f, 9'h0f3}, '{8'ha2, 7'h0c, 9'h100},
        '{8'ha3, 7'h41, 9'h14d}, '{8'ha4, 7'h04, 9'h188}, '{8'hb0, 7'h08, 9'h184}};
    iak_cpu_model i_cpu (.clk_sys, .go, .kind, .adr, .hold, .bus);
    iak_sequencer i_dut (.clk_sys, .nrst, .clk_en(1'b1), .bus, .io_block_switch(4'ha),
        .wait_switch(wsw), .cpu_type_jumper(jmp), .phantom_enable_switch(1'b0),
        .phantom_disable_switch(1'b0), .phantom_in_n(1'b1), .mem_addr_hit(hit), .irq_src(irq),
        .ack_in_progress_n(ack_n), .phantom_drive(), .phantom_out(), .phantom_oe_n(),
        .local_ack_strobe_n(stb_n), .master_ctrl_select_n(msel_n), .slave_ctrl_select_n(ssel_n),
        .master_strap(), .slave_strap(), .mem_select_n(memsel_n), .board_select(), .rdy(),
        .rd_n(), .irq_lines(irql));
    always #10 clk_sys = ~clk_sys;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one bus cycle, outputs snapped in the first data-in cycle
    task automatic cyc(input logic [1:0] k, input logic [7:0] a);
        @(posedge clk_sys);
        go <= 1'b1;
        kind <= k;
        adr <= a;
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 snap = {stb_n, msel_n, ssel_n, memsel_n, ack_n, 3'h0};
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        #1 chk({7'h0, ack_n}, 8'h01);
        foreach (rows[i])
        begin
            irq <= rows[i].irq;
            cyc(2'h3, rows[i].a);
            chk({6'h0, snap[6:5]}, {6'h0, rows[i].exp[8:7]});
            chk({1'b0, irql[6:0]}, {1'b0, rows[i].exp[6:0]});
        end
        repeat (3)
        begin
            cyc(2'h0, 8'h00);
            chk({3'h0, snap[7:3]}, 8'h0e);
        end
        hold <= 1'b1;
        cyc(2'h2, 8'h10);
        chk({3'h0, snap[7:3]}, 8'h1f);
        hold <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk({7'h0, ack_n}, 8'h00);
        @(posedge clk_sys);
        hold <= 1'b1;
        repeat (3) @(posedge clk_sys);
        hold <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk({7'h0, ack_n}, 8'h00);
        cyc(2'h2, 8'h10);
        chk({3'h0, snap[7:3]}, 8'h1f);
        jmp <= 1'b1;
        hit <= 1'b1;
        cyc(2'h0, 8'h00);
        cyc(2'h2, 8'h10);
        chk({3'h0, snap[7:3]}, 8'h0e);
        cyc(2'h1, 8'h10);
        chk({3'h0, snap[7:3]}, 8'h1d);
        wrap_up;
    end
    initial
    begin
        repeat (2000) @(posedge clk_sys);
        miscompares++;
        wrap_up;
    end
endmodule

/* File: verilog/iak_pkg.sv */
// package for the interrupt acknowledge sequencer
// assumes a single 50 MHz system clock and synchronous bus inputs
package iak_pkg;
    localparam int unsigned CLK_PERIOD_NS    = 20;
    // forced wait states on every acknowledge cycle
    localparam logic [3:0]  FORCED_WAITS     = 4'h2;
    // wait-state switch code width and wait counter reset value
    localparam int unsigned WAIT_CODE_W      = 4;
    localparam logic [3:0]  WAIT_CNT_RST     = 4'h0;
    // call response length in bytes
    localparam logic [1:0]  CALL_BYTES       = 2'h3;
    // port block decode: a[7:4] block, a[3:1] chip select, master is output 0
    localparam int unsigned BLK_HI           = 7;
    localparam int unsigned BLK_LO           = 4;
    localparam int unsigned SEL_HI           = 3;
    localparam int unsigned SEL_LO           = 1;
    localparam logic [2:0]  MASTER_SEL       = 3'h0;
    localparam logic [2:0]  SLAVE_SEL        = 3'h1;

    typedef enum logic [1:0] {
        IAK_IDLE = 2'b00,
        IAK_ACK  = 2'b01,
        IAK_HOLD = 2'b11
    } iak_state_e;

    // bus status and strobes sampled each clock
    typedef struct packed {
        logic       psync;
        logic       pstval_n;
        logic       sinta;
        logic       swo_n;
        logic       sinp;
        logic       sout;
        logic       pdbin;
        logic       phlda;
        logic [7:0] addr;
    } iak_bus_s;

    // interrupt request sources
    typedef struct packed {
        logic [2:0] timer_out;
        logic       serial_tx_ready;
        logic       serial_rx_ready;
        logic       math_end;
        logic       math_service_request;
    } iak_irq_s;
endpackage

/* File: verilog/iak_sequencer.sv */
// interrupt acknowledge sequencer for two cascaded vectored controllers
// assumes bus strobes are synchronous to clk_sys
`timescale 1ns/100ps
module iak_sequencer (
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire logic             clk_en,
    input  iak_pkg::iak_bus_s     bus,
    input  wire logic [3:0]       io_block_switch,
    input  wire logic [3:0]       wait_switch,
    input  wire logic             cpu_type_jumper,
    input  wire logic             phantom_enable_switch,
    input  wire logic             phantom_disable_switch,
    input  wire logic             phantom_in_n,
    input  wire logic             mem_addr_hit,
    input  iak_pkg::iak_irq_s     irq_src,
    output logic                  ack_in_progress_n,
    output logic                  phantom_drive,
    output logic                  phantom_out,
    output logic                  phantom_oe_n,
    output logic                  local_ack_strobe_n,
    output logic                  master_ctrl_select_n,
    output logic                  slave_ctrl_select_n,
    output logic                  master_strap,
    output logic                  slave_strap,
    output logic                  mem_select_n,
    output logic                  board_select,
    output logic                  rdy,
    output logic                  rd_n,
    output logic [7:0]            irq_lines
);

    // ----------------------------------------
    // decode helper
    // ----------------------------------------
    function automatic logic port_sel(input logic [7:0] a, input logic [3:0] blk,
                                      input logic [2:0] sel, input logic io);
        port_sel = io && (a[iak_pkg::BLK_HI:iak_pkg::BLK_LO] == blk)
                      && (a[iak_pkg::SEL_HI:iak_pkg::SEL_LO] == sel);
    endfunction

    // ----------------------------------------
    // acknowledge latch state
    // ----------------------------------------
    iak_pkg::iak_state_e state_r;
    iak_pkg::iak_state_e state_nxt;
    logic                stval_r;
    logic                stval_nxt;
    logic [3:0]          wait_r;
    logic [3:0]          wait_nxt;
    logic                psync_d_r;
    logic                psync_d_nxt;

    logic                latch_set;
    logic                in_prog;
    logic                ack_cyc;
    logic                io_cyc;
    logic                mast_cs;
    logic                slav_cs;
    logic                mem_hit;
    logic                any_sel;
    logic                wait_go;
    logic [3:0]          wait_load;
    logic                clr_ev;

    // ----------------------------------------
    // port decode
    // ----------------------------------------
    always_comb
    begin
        io_cyc  = bus.sinp | bus.sout;
        mast_cs = port_sel(bus.addr, io_block_switch, iak_pkg::MASTER_SEL, io_cyc);
        slav_cs = port_sel(bus.addr, io_block_switch, iak_pkg::SLAVE_SEL, io_cyc);
    end

    // ----------------------------------------
    // status valid flag
    // ----------------------------------------
    always_comb
    begin
        stval_nxt = stval_r;
        if (bus.psync && !bus.pstval_n)
            stval_nxt = 1'b1;
        else if (!bus.psync && psync_d_r)
            stval_nxt = 1'b0;
        psync_d_nxt = bus.psync;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            stval_r   <= 1'b0;
            psync_d_r <= 1'b0;
        end
        else if (clk_en)
        begin
            stval_r   <= stval_nxt;
            psync_d_r <= psync_d_nxt;
        end
    end

    // ----------------------------------------
    // acknowledge latch
    // ----------------------------------------
    always_comb
    begin
        latch_set = (state_r != iak_pkg::IAK_IDLE);
        in_prog   = latch_set && !bus.phlda;
        // clear condition selected by jumper
        if (cpu_type_jumper)
            clr_ev = stval_r && !bus.swo_n;
        else
            clr_ev = stval_r && !bus.sinta;
        clr_ev = clr_ev && !bus.phlda;

        state_nxt = state_r;
        case (state_r)
            iak_pkg::IAK_IDLE:
                if (bus.sinta && stval_r)
                    state_nxt = iak_pkg::IAK_ACK;
            iak_pkg::IAK_ACK:
                if (bus.phlda)
                    state_nxt = iak_pkg::IAK_HOLD;
                else if (clr_ev && !(bus.sinta && stval_r))
                    state_nxt = iak_pkg::IAK_IDLE;
            iak_pkg::IAK_HOLD:
                if (!bus.phlda)
                    state_nxt = iak_pkg::IAK_ACK;
            default:
                state_nxt = iak_pkg::IAK_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            state_r <= iak_pkg::IAK_IDLE;
        else if (clk_en)
            state_r <= state_nxt;
    end

    // ----------------------------------------
    // memory and board select
    // ----------------------------------------
    always_comb
    begin
        // phantom options, overridden by acknowledge
        mem_hit = mem_addr_hit && !io_cyc;
        if (phantom_enable_switch && !phantom_disable_switch)
            mem_hit = mem_hit && phantom_in_n;
        else if (phantom_disable_switch && !phantom_enable_switch)
            mem_hit = mem_hit && !phantom_in_n;
        mem_hit = mem_hit && !in_prog;

        any_sel = mast_cs || slav_cs || mem_hit || in_prog;
        // the latch only sets after psync, so the first acknowledge is seen on sinta
        ack_cyc = in_prog || (bus.sinta && bus.psync && !bus.phlda);
    end

    // ----------------------------------------
    // wait state counter
    // ----------------------------------------
    always_comb
    begin
        wait_load = wait_switch;
        if (ack_cyc && wait_load < iak_pkg::FORCED_WAITS)
            wait_load = iak_pkg::FORCED_WAITS;
        wait_go  = bus.psync && (any_sel || ack_cyc);
        wait_nxt = wait_r;
        if (wait_go)
            wait_nxt = wait_load;
        else if (wait_r != iak_pkg::WAIT_CNT_RST)
            wait_nxt = wait_r - 4'h1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            wait_r <= iak_pkg::WAIT_CNT_RST;
        else if (clk_en)
            wait_r <= wait_nxt;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_comb
    begin
        ack_in_progress_n    = !in_prog;
        phantom_drive        = in_prog;
        phantom_out          = 1'b0;
        phantom_oe_n         = !in_prog;
        local_ack_strobe_n   = !(in_prog && bus.pdbin);
        master_ctrl_select_n = !mast_cs;
        slave_ctrl_select_n  = !slav_cs;
        master_strap         = 1'b1;
        slave_strap          = 1'b0;
        mem_select_n         = !mem_hit;
        board_select         = any_sel;
        rdy                  = (wait_r == iak_pkg::WAIT_CNT_RST) &&
                               !(wait_go && wait_load != iak_pkg::WAIT_CNT_RST);
        rd_n                 = !(any_sel && bus.pdbin);
        irq_lines            = {1'b0, irq_src.timer_out, !irq_src.serial_tx_ready,
                                !irq_src.serial_rx_ready, irq_src.math_end,
                                irq_src.math_service_request};
    end

endmodule
